// [gtsl_regs.svh]
`ifndef GTSL_REGS_SVH
`define GTSL_REGS_SVH
// sample width of the differential signal
`define GTSL_SAMPLE_W      12
// start hysteresis, peak-to-peak, in sample counts
`define GTSL_START_HYS     12'h0_0C8
// threshold placement: fraction of peak-to-peak as shift (1/4 from each peak)
`define GTSL_THR_SHIFT     2
// limit on inward threshold movement per update, as shift of the step
`define GTSL_INWARD_SHIFT  3
// number of high peaks used for gain calibration
`define GTSL_CAL_PEAKS     2'h3
// power-up settle time in ns and derived cycles at 100 ns period
`define GTSL_SETTLE_NS     1000
`define GTSL_CLK_NS        100
`define GTSL_SETTLE_CYC    ((`GTSL_SETTLE_NS + `GTSL_CLK_NS - 1) / `GTSL_CLK_NS)
`endif

// [gtsl_pkg.sv]
package gtsl_pkg;
  typedef logic signed [11:0] gtsl_sample_t;
  // one-hot start/run states
  typedef enum logic [3:0] {
    GTSL_SETTLE = 4'b0001,
    GTSL_HYS    = 4'b0010,
    GTSL_CAL    = 4'b0100,
    GTSL_RUN    = 4'b1000
  } gtsl_state_t;
endpackage : gtsl_pkg

// [gtsl_peak_if.sv]
`timescale 1ns/1ps
// peak tracker link: sample in, tracked extremes out
interface gtsl_peak_if;
  logic                 load;
  logic                 rise_edge;
  logic                 fall_edge;
  gtsl_pkg::gtsl_sample_t sample;
  gtsl_pkg::gtsl_sample_t pk_hi;
  gtsl_pkg::gtsl_sample_t pk_lo;
  modport tracker (input load, rise_edge, fall_edge, sample, output pk_hi, pk_lo);
  modport user    (output load, rise_edge, fall_edge, sample, input pk_hi, pk_lo);
endinterface : gtsl_peak_if

// [gtsl_peak_track.sv]
`timescale 1ns/1ps
`include "gtsl_regs.svh"
// tracks high and low peaks; a rising output edge restarts the high peak, a falling edge the low peak
module gtsl_peak_track (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  gtsl_peak_if.tracker   pk
);
  wire new_hi = pk.sample > pk.pk_hi;
  wire new_lo = pk.sample < pk.pk_lo;

  // rising edge starts a fresh high peak search, falling a fresh low one
  always_ff @(posedge clk) begin
    if (rst) begin
      pk.pk_hi <= '0;
      pk.pk_lo <= '0;
    end else if (ce) begin
      if (pk.load || pk.rise_edge || new_hi) pk.pk_hi <= pk.sample;
      if (pk.load || pk.fall_edge || new_lo) pk.pk_lo <= pk.sample;
    end
  end
endmodule : gtsl_peak_track

// [gtsl_switch.sv]
`timescale 1ns/1ps
`include "gtsl_regs.svh"
module gtsl_switch (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   sample_valid,
  input  wire gtsl_pkg::gtsl_sample_t differential_signal,
  input  wire logic                   undervoltage,
  output logic                        high_current_state,
  output logic                        running_mode,
  output logic                        switching_enabled,
  output gtsl_pkg::gtsl_sample_t      gain_peak_sum
);
  // undervoltage is asynchronous to clk, so two flops first
  logic uv_meta;
  logic uv_sync;
  always_ff @(posedge clk) begin
    if (rst) begin
      uv_meta <= 1'b1;
      uv_sync <= 1'b1;
    end else if (ce) begin
      uv_meta <= undervoltage;
      uv_sync <= uv_meta;
    end
  end

  gtsl_pkg::gtsl_state_t state;
  gtsl_pkg::gtsl_state_t next_state;
  gtsl_pkg::gtsl_sample_t op_thr;
  gtsl_pkg::gtsl_sample_t rp_thr;
  logic [3:0]             settle_cnt;
  logic [1:0]             cal_cnt;
  logic                   out_q;
  logic                   thr_ok;

  gtsl_peak_if pk ();
  gtsl_peak_track u_peak (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .pk  (pk)
  );

  // decoding of the state and of the sample stream
  wire in_hys    = state == gtsl_pkg::GTSL_HYS;
  wire in_cal    = state == gtsl_pkg::GTSL_CAL;
  wire in_run    = state == gtsl_pkg::GTSL_RUN;
  // no switch events during lockout, so thresholds do not creep meanwhile
  wire live      = sample_valid && !uv_sync && (in_cal || in_run);
  // peak-to-peak against the extremes seen since settle, not a single sample
  wire signed [12:0] exc_hi = 13'(differential_signal) - 13'(pk.pk_lo);
  wire signed [12:0] exc_lo = 13'(pk.pk_hi) - 13'(differential_signal);
  // signed compare: an unsigned limit would turn negative excursions huge
  wire hys_hi    = exc_hi > $signed(13'(`GTSL_START_HYS));
  wire hys_lo    = exc_lo > $signed(13'(`GTSL_START_HYS));
  wire hys_hit   = in_hys && sample_valid && (hys_hi || hys_lo);
  wire rise_cross = live && !out_q && thr_ok && differential_signal >= op_thr;
  wire fall_cross = live && out_q && thr_ok && differential_signal <= rp_thr;
  // low-side start switches low at once, high-side start makes no edge
  wire start_low  = hys_hit && hys_lo;
  wire rise_ev    = rise_cross;
  wire fall_ev    = fall_cross || start_low;

  assign pk.sample    = differential_signal;
  assign pk.load      = (state == gtsl_pkg::GTSL_SETTLE);
  assign pk.rise_edge = rise_ev;
  assign pk.fall_edge = fall_ev;

  // target thresholds a quarter in from each peak of the last two edges
  wire signed [12:0] span    = 13'(pk.pk_hi) - 13'(pk.pk_lo);
  wire signed [12:0] quarter = span >>> `GTSL_THR_SHIFT;
  wire gtsl_pkg::gtsl_sample_t op_tgt = 12'(13'(pk.pk_hi) - quarter);
  wire gtsl_pkg::gtsl_sample_t rp_tgt = 12'(13'(pk.pk_lo) + quarter);
  // inward moves (op down, rp up) only go part way; outward moves are taken whole
  wire signed [12:0] op_step = (13'(op_thr) - 13'(op_tgt)) >>> `GTSL_INWARD_SHIFT;
  wire signed [12:0] rp_step = (13'(rp_tgt) - 13'(rp_thr)) >>> `GTSL_INWARD_SHIFT;
  wire gtsl_pkg::gtsl_sample_t op_lim =
    (op_tgt < op_thr) ? 12'(13'(op_thr) - op_step) : op_tgt;
  wire gtsl_pkg::gtsl_sample_t rp_lim =
    (rp_tgt > rp_thr) ? 12'(13'(rp_thr) + rp_step) : rp_tgt;

  // start sequence: settle, hysteresis wait, calibration, running
  always_comb begin
    next_state = state;
    unique case (state)
      gtsl_pkg::GTSL_SETTLE: if (settle_cnt == 4'(`GTSL_SETTLE_CYC)) next_state = gtsl_pkg::GTSL_HYS;
      gtsl_pkg::GTSL_HYS:    if (hys_hit) next_state = gtsl_pkg::GTSL_CAL;
      gtsl_pkg::GTSL_CAL:    if (rise_ev && cal_cnt == `GTSL_CAL_PEAKS - 2'h1)
                               next_state = gtsl_pkg::GTSL_RUN;
      gtsl_pkg::GTSL_RUN:    next_state = state;
      default:               next_state = gtsl_pkg::GTSL_SETTLE;
    endcase
  end

  // sequencing registers; reset returns to uncalibrated start
  always_ff @(posedge clk) begin
    if (rst) begin
      state      <= gtsl_pkg::GTSL_SETTLE;
      settle_cnt <= 4'h0;
      cal_cnt    <= 2'h0;
    end else if (ce) begin
      state <= next_state;
      if (state == gtsl_pkg::GTSL_SETTLE) settle_cnt <= settle_cnt + 4'h1;
      if (in_cal && rise_ev) cal_cnt <= cal_cnt + 2'h1;
    end
  end

  // threshold registers, refreshed on every output edge except the rise forced by undervoltage
  always_ff @(posedge clk) begin
    if (rst) begin
      op_thr <= '0;
      rp_thr <= '0;
      thr_ok <= 1'b0;
    end else if (ce) begin
      if (hys_hit) begin
        // the crossing sample becomes the first switchpoint
        op_thr <= hys_hi ? differential_signal : pk.pk_hi;
        rp_thr <= hys_hi ? pk.pk_lo : differential_signal;
        thr_ok <= 1'b1;
      end else if (rise_ev || fall_ev) begin
        op_thr <= op_lim;
        rp_thr <= rp_lim;
      end
    end
  end

  // output state; high until switching, forced high on undervoltage
  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= 1'b1;
    end else if (ce) begin
      if (uv_sync) out_q <= 1'b1;
      else if (fall_ev) out_q <= 1'b0;
      else if (rise_ev) out_q <= 1'b1;
      // a high-side start leaves out_q high: no edge
    end
  end

  // gain calibration accumulates a quarter of each rising-edge high peak
  always_ff @(posedge clk) begin
    if (rst) begin
      gain_peak_sum <= '0;
    end else if (ce && in_cal && rise_ev) begin
      gain_peak_sum <= 12'(gain_peak_sum + (pk.pk_hi >>> 2));
    end
  end

  // registered status outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      high_current_state <= 1'b1;
      running_mode       <= 1'b0;
      switching_enabled  <= 1'b0;
    end else if (ce) begin
      high_current_state <= out_q;
      running_mode       <= in_run;
      switching_enabled  <= thr_ok;
    end
  end
endmodule : gtsl_switch

// [gtsl_sense_model.sv]
`timescale 1ns/1ps
// controller side: sense resistor turns supply current into a voltage
module gtsl_sense_model #(
  parameter bit HIGH_SIDE = 1'h0
) (
  input  wire logic high_current_state,
  output logic      sensed_voltage
);
  // supply-side resistor drops more at high current, so that reading inverts
  assign sensed_voltage = HIGH_SIDE ? ~high_current_state : high_current_state;
endmodule : gtsl_sense_model

// [gtsl_switch_sva.sv]
`timescale 1ns/1ps
module gtsl_switch_sva (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic                   sample_valid,
  input wire gtsl_pkg::gtsl_sample_t differential_signal,
  input wire logic                   undervoltage,
  input wire logic                   high_current_state,
  input wire logic                   running_mode,
  input wire logic                   switching_enabled,
  input wire gtsl_pkg::gtsl_sample_t gain_peak_sum
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // start state checked through reset itself, so no disable here
  a_reset_start: assert property (disable iff (1'h0)
    rst && ce |=> high_current_state && !running_mode && !switching_enabled)
    else $error("start state wrong after reset");
  // settle window: nothing may switch right after release
  a_settle_quiet: assert property ($fell(rst) |->
    (high_current_state && !switching_enabled)[*8]) else $error("switched during settle");
  // supply monitor to output is four edges: two sync flops, out_q, status flop
  a_uv_forces_high: assert property ((undervoltage && ce)[*5] |->
    high_current_state) else $error("low supply did not force high");
  a_low_needs_enable: assert property ($fell(high_current_state) |->
    switching_enabled) else $error("output fell before threshold set");
  a_enable_sticky: assert property (switching_enabled |=> switching_enabled)
    else $error("switching enable dropped");
  a_run_sticky: assert property (running_mode |=> running_mode)
    else $error("running mode dropped");
  a_run_after_enable: assert property (running_mode |-> switching_enabled)
    else $error("running before threshold set");
  a_sum_idle: assert property (!switching_enabled |-> gain_peak_sum == 12'h000)
    else $error("gain sum moved before start");
  a_ce_freeze: assert property (!ce |=> $stable(high_current_state))
    else $error("output moved with clock enable low");
  c_low_start: cover property ($rose(switching_enabled) && !high_current_state);
  c_run: cover property ($rose(running_mode));
  c_fall: cover property ($fell(high_current_state));
  c_high_start: cover property ($rose(switching_enabled) && high_current_state);
endmodule : gtsl_switch_sva

bind gtsl_switch gtsl_switch_sva chk_u (.clk(clk), .rst(rst), .ce(ce),
  .sample_valid(sample_valid), .differential_signal(differential_signal),
  .undervoltage(undervoltage), .high_current_state(high_current_state),
  .running_mode(running_mode), .switching_enabled(switching_enabled),
  .gain_peak_sum(gain_peak_sum));

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct { gtsl_pkg::gtsl_sample_t sig; logic out; } gtsl_row_t;
  logic                   clk = 1'h0;
  logic                   rst = 1'h1;
  logic                   ce = 1'h1;
  logic                   sample_valid = 1'h1;
  gtsl_pkg::gtsl_sample_t differential_signal = 12'h000;
  logic                   undervoltage = 1'h0;
  logic                   high_current_state, running_mode, switching_enabled;
  logic                   sense_hi, sense_lo;
  gtsl_pkg::gtsl_sample_t gain_peak_sum;
  int                     fail_count = 0;
  int                     check_count = 0;
  // high-side start at +300, then full swings of +/-1000 for calibration
  gtsl_row_t rows [11] = '{'{12'h000, 1'h1}, '{12'h12C, 1'h1}, '{12'hC18, 1'h0},
    '{12'h3E8, 1'h1}, '{12'hC18, 1'h0}, '{12'h3E8, 1'h1}, '{12'hC18, 1'h0},
    '{12'h3E8, 1'h1}, '{12'hC18, 1'h0}, '{12'h3E8, 1'h1}, '{12'hC18, 1'h0}};

  always #50 clk = ~clk;

  gtsl_switch dut_u (.clk(clk), .rst(rst), .ce(ce), .sample_valid(sample_valid),
    .differential_signal(differential_signal), .undervoltage(undervoltage),
    .high_current_state(high_current_state), .running_mode(running_mode),
    .switching_enabled(switching_enabled), .gain_peak_sum(gain_peak_sum));
  gtsl_sense_model #(.HIGH_SIDE(1'h1)) hi_u (.high_current_state(high_current_state),
    .sensed_voltage(sense_hi));
  gtsl_sense_model #(.HIGH_SIDE(1'h0)) lo_u (.high_current_state(high_current_state),
    .sensed_voltage(sense_lo));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // apply one level, let it stand n edges, look at the settled outputs
  task automatic hold(input gtsl_pkg::gtsl_sample_t v, input int n);
    @(posedge clk) differential_signal <= v;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : hold

  task automatic end_sim;
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk(high_current_state, 1'h1);
    chk(gain_peak_sum, 12'h000);
    hold(12'h000, 15);
    chk(switching_enabled, 1'h0);
    foreach (rows[i]) begin
      hold(rows[i].sig, 8);
      chk(high_current_state, rows[i].out);
      chk(sense_lo, rows[i].out);
      chk(sense_hi, !rows[i].out);
    end
    chk(switching_enabled, 1'h1);
    chk(running_mode, 1'h1);
    chk(gain_peak_sum, 12'h23F);
    @(posedge clk) undervoltage <= 1'h1;
    hold(12'hC18, 6);
    chk(high_current_state, 1'h1);
    @(posedge clk) undervoltage <= 1'h0;
    hold(12'h3E8, 8);
    chk(high_current_state, 1'h1);
    hold(12'hC18, 8);
    chk(high_current_state, 1'h0);
    // shrinking swing: operate point may only creep inward
    hold(12'h258, 8);
    chk(high_current_state, 1'h1);
    hold(12'hDA8, 8);
    chk(high_current_state, 1'h0);
    hold(12'h12C, 8);
    chk(high_current_state, 1'h0);
    hold(12'h1E0, 8);
    chk(high_current_state, 1'h1);
    // clock enable low freezes, invalid samples are ignored
    @(posedge clk) ce <= 1'h0;
    hold(12'hC18, 8);
    chk(high_current_state, 1'h1);
    @(posedge clk) ce <= 1'h1;
    hold(12'hC18, 8);
    chk(high_current_state, 1'h0);
    @(posedge clk) sample_valid <= 1'h0;
    hold(12'h3E8, 8);
    chk(high_current_state, 1'h0);
    @(posedge clk) sample_valid <= 1'h1;
    hold(12'h3E8, 8);
    chk(high_current_state, 1'h1);
    // mid-run reset, then a low-side start
    @(posedge clk) rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    hold(12'h000, 15);
    chk(running_mode, 1'h0);
    // a swing of exactly the start hysteresis must not start anything
    hold(12'h064, 8);
    chk(switching_enabled, 1'h0);
    hold(12'hF9C, 8);
    chk(switching_enabled, 1'h0);
    hold(12'hED4, 4);
    chk(high_current_state, 1'h0);
    chk(switching_enabled, 1'h1);
    end_sim();
  end

  // watchdog: the run needs about 265 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    end_sim();
  end
endmodule : tb_top
